// ===== include/bts_pkg.sv
// Constants, types and register map for the bus transfer scheme logic.
// Assumes a 50 MHz clock and APB access with 32-bit aligned registers.
// Summary of operation
// - Idle incomer energizes outputs 1 and 4, releases 5-7, shows not ready.
// - Idle bus-tie controller keeps outputs 4 through 7 released.
// - Bus-tie breaker connected energizes bus-tie outputs 4 and 6.
// - Bus-tie connected lost releases 4 and 6; incomers show not ready.
// - Incomer closes on remote close only once healthy line voltage appears.
// - Incomer breaker disconnected releases 5 and 7; both incomers not ready.
// - Remote-open pulse trips incomer, releases 5 and 7, shows not ready.
// - Remote-close pulse closes incomer, energizes 5 and 7, clears not ready.
// - Remote-close pulse closes bus tie, energizes 5 and 7; incomers not ready.
// - Remote-open pulse trips bus tie, releases 5 and 7; not ready clears.
// - Block transfer releases incomer outputs 5 and 7 and shows not ready.
// - First undervoltage energizes output 4; peer incomer shows not ready.
// - Undervoltage reset releases 4; peer clears not ready after delay.
// - Timed undervoltage timeout trips the incomer breaker.
// - Transformer lockout trips incomer and energizes output 6 close request.
// - Output 6 close request drops as soon as the breaker has tripped.
// - Request from incomer 1 closes bus tie only when bus is dead.
// - Request from incomer 2 closes bus tie only when line is dead.
package bts_pkg;

  // Contact and element input positions within the synchronised vector
  localparam int IN_CONN = 0;
  localparam int IN_RCLOSE = 1;
  localparam int IN_ROPEN = 2;
  localparam int IN_BLOCK = 3;
  localparam int IN_LOCKOUT = 4;
  localparam int IN_CLOSED = 5;
  localparam int IN_UVFAST = 6;
  localparam int IN_UVTIMED = 7;
  localparam int IN_LINELIVE = 8;
  localparam int IN_BUSDEAD = 9;
  localparam int IN_LINEDEAD = 10;
  localparam int IN_REQ1 = 11;
  localparam int IN_REQ2 = 12;
  localparam int IN_PEERRDY = 13;
  localparam int IN_PEERUV = 14;
  localparam int IN_TIECONN = 15;
  localparam int IN_TIECLOSED = 16;
  localparam int NIN = 17;

  // Output relay positions; relay number k sits at bit k-1
  localparam int RLY_TRIP = 0;
  localparam int RLY_CLOSE = 1;
  localparam int RLY_NRDY = 2;
  localparam int RLY_UV = 3;
  localparam int RLY_RDY_A = 4;
  localparam int RLY_REQ = 5;
  localparam int RLY_RDY_B = 6;
  localparam int NRLY = 7;

  // Register byte offsets
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_DELAY = 12'h004;
  localparam logic [11:0] OFS_STATUS = 12'h008;
  localparam logic [11:0] OFS_INPUTS = 12'h00C;

  // Control fields and reset values
  localparam int CTRL_ROLE_LSB = 0;
  localparam int CTRL_EN_BIT = 2;
  localparam logic [31:0] CTRL_RST = 32'h0000_0004;
  localparam logic [15:0] DELAY_RST = 16'h0064;

  // Status fields
  localparam int ST_NRDY_BIT = 7;
  localparam int ST_BK_LSB = 8;
  localparam int ST_CPEND_BIT = 10;
  localparam int ST_R1PEND_BIT = 11;
  localparam int ST_R2PEND_BIT = 12;
  localparam int ST_DLY_BIT = 13;

  // Timing: the transfer delay setpoint counts whole milliseconds
  localparam int CLK_PERIOD_NS = 20;
  localparam int ONE_MS_NS = 1_000_000;
  localparam int MS_CYCLES_DFLT = ONE_MS_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {ROLE_INC1, ROLE_INC2, ROLE_TIE} bts_role_t;
  typedef enum logic [1:0] {BK_IDLE, BK_CLOSING, BK_TRIPPING} bts_bk_t;

endpackage : bts_pkg

// ===== rtl/bts_in_sync.sv
// Two-stage synchronisers and rising-edge detect for the contact inputs.
// Assumes every input is asynchronous to clk; outputs are registered.
`timescale 1ns/1ns
`default_nettype none
module bts_in_sync
  import bts_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [bts_pkg::NIN-1:0] din,
  output logic [bts_pkg::NIN-1:0] level,
  output logic [bts_pkg::NIN-1:0] rise
);
  import bts_pkg::*;

  typedef struct packed {
    logic [NIN-1:0] s1;
    logic [NIN-1:0] s2;
    logic [NIN-1:0] s3;
    logic [NIN-1:0] rise;
  } bts_sync_t;

  bts_sync_t r;
  bts_sync_t n;

  // First stage feeds only the second; edges are taken after stage two
  always_comb begin
    n = r;
    n.s1 = din;
    n.s2 = r.s1;
    n.s3 = r.s2;
    n.rise = r.s2 & ~r.s3;
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign level = r.s2;
  assign rise = r.rise;

endmodule : bts_in_sync
`default_nettype wire

// ===== rtl/bts_scheme_top.sv
// Scheme logic of one transfer relay: incomer 1, incomer 2 or bus tie.
// Assumes contact and element flags arrive asynchronously on pins and
// that software sets role and transfer delay over APB.
//
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module bts_scheme_top
  import bts_pkg::*;
#(
  parameter int MS_CYCLES = bts_pkg::MS_CYCLES_DFLT
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic brkConnIn,
  input wire logic remCloseIn,
  input wire logic remOpenIn,
  input wire logic blockXferIn,
  input wire logic lockoutIn,
  input wire logic brkClosedIn,
  input wire logic uvFastIn,
  input wire logic uvTimedIn,
  input wire logic lineLiveIn,
  input wire logic busDeadIn,
  input wire logic lineDeadIn,
  input wire logic reqInc1In,
  input wire logic reqInc2In,
  input wire logic peerReadyIn,
  input wire logic peerUvIn,
  input wire logic tieConnIn,
  input wire logic tieClosedIn,
  output logic [bts_pkg::NRLY-1:0] relayOut,
  output logic notReady
);
  import bts_pkg::*;

  // Everything the block remembers outside the synchroniser sits in one packed struct: the
  // software settings, the bus answer, the breaker sequencer, the
  // pending commands, the delay counters and the relay images.
  // Keeping it in one register makes the reset state easy to audit.
  typedef struct packed {
    logic [1:0] role;
    logic enable;
    logic [15:0] delayMs;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    bts_bk_t bk;
    logic closePend;
    logic req1Pend;
    logic req2Pend;
    logic reqOut;
    logic [15:0] dlyCnt;
    logic [15:0] preCnt;
    logic [NRLY-1:0] relay;
    logic notReady;
  } bts_state_t;

  // Last value of the millisecond prescaler; the cast keeps the
  // parameter arithmetic at the counter's own width.
  localparam logic [15:0] MS_LAST = 16'(MS_CYCLES - 1);

  // r is the registered state, n its next value
  bts_state_t r;
  bts_state_t n;
  logic [NIN-1:0] rawIn;
  logic [NIN-1:0] lv;
  logic [NIN-1:0] rs;
  logic isTie;
  logic mapped;
  logic [31:0] rdMux;
  logic tripCond;
  logic closeCond;
  logic ownReady;
  logic uvOut;
  logic dlyRun;

  // Every contact and element flag comes from another domain, so
  // none of them is read before it has passed the synchroniser.
  // Pin inputs gathered into one vector for the synchronisers
  assign rawIn[IN_CONN] = brkConnIn;
  assign rawIn[IN_RCLOSE] = remCloseIn;
  assign rawIn[IN_ROPEN] = remOpenIn;
  assign rawIn[IN_BLOCK] = blockXferIn;
  assign rawIn[IN_LOCKOUT] = lockoutIn;
  assign rawIn[IN_CLOSED] = brkClosedIn;
  assign rawIn[IN_UVFAST] = uvFastIn;
  assign rawIn[IN_UVTIMED] = uvTimedIn;
  assign rawIn[IN_LINELIVE] = lineLiveIn;
  assign rawIn[IN_BUSDEAD] = busDeadIn;
  assign rawIn[IN_LINEDEAD] = lineDeadIn;
  assign rawIn[IN_REQ1] = reqInc1In;
  assign rawIn[IN_REQ2] = reqInc2In;
  assign rawIn[IN_PEERRDY] = peerReadyIn;
  assign rawIn[IN_PEERUV] = peerUvIn;
  assign rawIn[IN_TIECONN] = tieConnIn;
  assign rawIn[IN_TIECLOSED] = tieClosedIn;

  // Levels come out after two flops; rising edges one flop later,
  // so a command edge always trails the level that it belongs to.
  bts_in_sync u_sync (
    .clk(clk),
    .rstn(rstn),
    .din(rawIn),
    .level(lv),
    .rise(rs)
  );

  // Decode is on the full byte address, so a misaligned or unused
  // offset reads as zero and answers with an error.
  // Read data selection and address decode for the APB slave
  always_comb begin
    mapped = 1'b1;
    rdMux = 32'h0000_0000;
    case (paddr)
      OFS_CTRL: begin
        rdMux[CTRL_ROLE_LSB +: 2] = r.role;
        rdMux[CTRL_EN_BIT] = r.enable;
      end
      OFS_DELAY: begin
        rdMux[15:0] = r.delayMs;
      end
      // Status is a snapshot for diagnostics; nothing in it is sticky
      OFS_STATUS: begin
        rdMux[NRLY-1:0] = r.relay;
        rdMux[ST_NRDY_BIT] = r.notReady;
        rdMux[ST_BK_LSB +: 2] = r.bk;
        rdMux[ST_CPEND_BIT] = r.closePend;
        rdMux[ST_R1PEND_BIT] = r.req1Pend;
        rdMux[ST_R2PEND_BIT] = r.req2Pend;
        rdMux[ST_DLY_BIT] = (r.dlyCnt != 16'h0000);
      end
      OFS_INPUTS: begin
        rdMux[NIN-1:0] = lv;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // Next state: bus slave, breaker command sequencing and relay outputs
  always_comb begin
    n = r;
    isTie = (r.role == ROLE_TIE);
    tripCond = 1'b0;
    closeCond = 1'b0;

    // Read data are captured at the setup edge and then held, so a
    // master that samples late still sees the value it asked for.
    // Answer in the first access cycle; writes land at that edge
    n.pready = 1'b0;
    n.pslverr = 1'b0;
    if (psel && !penable) begin
      n.pready = 1'b1;
      n.pslverr = !mapped;
      n.prdata = rdMux;
    end
    // The write lands at the access edge, the only edge at which
    // psel, penable and pready are all high together.
    if (psel && penable && r.pready && pwrite) begin
      if (paddr == OFS_CTRL) begin
        n.role = pwdata[CTRL_ROLE_LSB +: 2];
        n.enable = pwdata[CTRL_EN_BIT];
      end
      if (paddr == OFS_DELAY) begin
        n.delayMs = pwdata[15:0];
      end
    end

    // A close command that cannot be carried out yet is remembered
    // rather than dropped; an open command, a closed breaker, a lost
    // connection or a disabled scheme forgets it.
    // Pending close requests; a new edge wins over a same-cycle clear
    if (lv[IN_CLOSED] || rs[IN_ROPEN] || !lv[IN_CONN] || !r.enable) begin
      n.closePend = 1'b0;
      n.req1Pend = 1'b0;
      n.req2Pend = 1'b0;
    end
    if (rs[IN_RCLOSE]) begin
      n.closePend = 1'b1;
    end
    if (isTie && rs[IN_REQ1]) begin
      n.req1Pend = 1'b1;
    end
    if (isTie && rs[IN_REQ2]) begin
      n.req2Pend = 1'b1;
    end

    // Incomer trips need a closed breaker, so a breaker that is
    // already open starts no new trip sequence; its trip relay is held in by the open-contact term instead. The bus
    // tie honours a remote open whenever the scheme is enabled.
    // Trip and close conditions per role
    if (isTie) begin
      tripCond = rs[IN_ROPEN];
      closeCond = lv[IN_CONN] && !lv[IN_CLOSED] &&
        (r.closePend ||
         (r.req1Pend && lv[IN_BUSDEAD]) ||
         (r.req2Pend && lv[IN_LINEDEAD]));
    end else begin
      tripCond = lv[IN_CLOSED] &&
        (rs[IN_ROPEN] ||
         lv[IN_UVTIMED] ||
         lv[IN_LOCKOUT]);
      closeCond = r.closePend && lv[IN_CONN] && !lv[IN_CLOSED] &&
        lv[IN_LINELIVE] && !lv[IN_UVFAST] &&
        !lv[IN_LOCKOUT];
    end
    // A disabled scheme starts no trip or close sequence at all
    tripCond = tripCond && r.enable;
    closeCond = closeCond && r.enable;

    // Commands are held as levels until the auxiliary contact
    // confirms the move; a breaker that never opens keeps its trip
    // coil energized, since only its contact ends the trip.
    // Breaker sequencer: a trip always overrides a close in progress
    case (r.bk)
      BK_IDLE: begin
        if (tripCond) begin
          n.bk = BK_TRIPPING;
        end else if (closeCond) begin
          n.bk = BK_CLOSING;
        end
      end
      BK_CLOSING: begin
        if (tripCond) begin
          n.bk = BK_TRIPPING;
        end else if (lv[IN_CLOSED] || !lv[IN_CONN] || !r.enable) begin
          n.bk = BK_IDLE;
        end
      end
      BK_TRIPPING: begin
        if (!lv[IN_CLOSED]) begin
          n.bk = BK_IDLE;
        end
      end
      default: begin
        n.bk = BK_IDLE;
      end
    endcase

    // The request is raised only while this breaker is still closed,
    // so the bus tie never sees a request from a breaker already out.
    // Close request to the bus tie, held until the breaker is open
    if (!lv[IN_CLOSED]) begin
      n.reqOut = 1'b0;
    end
    if (!isTie && r.enable && lv[IN_CLOSED] &&
        (lv[IN_LOCKOUT] || lv[IN_UVTIMED])) begin
      n.reqOut = 1'b1;
    end

    // The delay is reloaded for as long as the peer sags, so a sag
    // that flickers restarts the full wait instead of shortening it.
    // A setpoint of zero gives no extra wait at all.
    // Other-source delay: restarts while the peer undervoltage is up
    if (lv[IN_PEERUV]) begin
      n.dlyCnt = r.delayMs;
      n.preCnt = 16'h0000;
    end else if (r.dlyCnt != 16'h0000) begin
      if (r.preCnt >= MS_LAST) begin
        n.preCnt = 16'h0000;
        n.dlyCnt = r.dlyCnt - 16'h0001;
      end else begin
        n.preCnt = r.preCnt + 16'h0001;
      end
    end
    dlyRun = lv[IN_PEERUV] || (r.dlyCnt != 16'h0000);

    // Readiness of this breaker for a transfer
    ownReady = lv[IN_CONN] && lv[IN_CLOSED] &&
      !lv[IN_BLOCK];
    // Without line voltage the sag relay is energized, which is why an
    // idle incomer shows relay 4 picked up.
    uvOut = !lv[IN_LINELIVE] || lv[IN_UVFAST];

    // Relays are computed from the next sequencer state so that the
    // close and trip coils change in the same cycle as the sequencer
    // and can never be energized together.
    // Trip relay stays in while the breaker is open and not closing
    n.relay = '0;
    n.relay[RLY_TRIP] = (n.bk == BK_TRIPPING) ||
      ((n.bk != BK_CLOSING) && !lv[IN_CLOSED]);
    n.relay[RLY_CLOSE] = (n.bk == BK_CLOSING);
    // The bus tie has no transfer-ready indication of its own; its
    // relays 4 to 7 report connection and closed position to the
    // incomers instead.
    if (isTie) begin
      n.notReady = 1'b0;
      n.relay[RLY_UV] = lv[IN_CONN];
      n.relay[RLY_REQ] = lv[IN_CONN];
      n.relay[RLY_RDY_A] = lv[IN_CLOSED] && lv[IN_CONN];
      n.relay[RLY_RDY_B] = lv[IN_CLOSED] && lv[IN_CONN];
    end else begin
      n.notReady = !ownReady || !lv[IN_PEERRDY] ||
        !lv[IN_TIECONN] || lv[IN_TIECLOSED] ||
        dlyRun;
      n.relay[RLY_NRDY] = n.notReady;
      n.relay[RLY_UV] = uvOut;
      n.relay[RLY_RDY_A] = ownReady;
      n.relay[RLY_RDY_B] = ownReady;
      n.relay[RLY_REQ] = n.reqOut;
    end
  end

  // Reset drops every relay; the not-ready flag comes up at once so
  // that no peer takes this incomer as ready during reset.
  // Single state register; synchronous reset to the idle scheme state
  always_ff @(posedge clk) begin
    if (!rstn) begin
      r.role <= CTRL_RST[CTRL_ROLE_LSB +: 2];
      r.enable <= CTRL_RST[CTRL_EN_BIT];
      r.delayMs <= DELAY_RST;
      r.pready <= 1'b0;
      r.pslverr <= 1'b0;
      r.prdata <= 32'h0000_0000;
      r.bk <= BK_IDLE;
      r.closePend <= 1'b0;
      r.req1Pend <= 1'b0;
      r.req2Pend <= 1'b0;
      r.reqOut <= 1'b0;
      r.dlyCnt <= 16'h0000;
      r.preCnt <= 16'h0000;
      r.relay <= '0;
      r.notReady <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // All outputs are taken straight from the state register
  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign relayOut = r.relay;
  assign notReady = r.notReady;

endmodule : bts_scheme_top
`default_nettype wire

// ===== sim/bts_breaker_model.sv
// Breaker model: aux contact follows close and trip relays after travel.
// Assumes both commands are level relay outputs held until done.
`timescale 1ns/1ns
`default_nettype none
module bts_breaker_model #(
  parameter int DLY = 5
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic closeCmd,
  input wire logic tripCmd,
  output logic closed
);
  int cnt_r;
  // A command dropped mid-stroke aborts it, like a real mechanism
  always @(posedge clk) begin
    if (!rstn || !(closed ? tripCmd : closeCmd)) cnt_r <= 0;
    else cnt_r <= cnt_r + 1;
    if (!rstn) closed <= 1'b0;
    else if (cnt_r == DLY) closed <= !closed;
  end
endmodule : bts_breaker_model
`default_nettype wire

// ===== sim/bts_scheme_asserts.sv
// Concurrent checks on the ports of the transfer scheme top.
// Assumes binding into bts_scheme_top; one clock, reset active low.
`timescale 1ns/1ns
`default_nettype none
module bts_scheme_asserts (
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic brkClosedIn,
  input wire logic lockoutIn,
  input wire logic peerUvIn,
  input wire logic [6:0] relayOut,
  input wire logic notReady
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  // Bus answers with no wait state, for one cycle only
  a_apb_zero_wait: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("answer held too long");
  a_unmapped_err: assert property (pready && paddr[11:4] != 0 |-> pslverr)
    else $error("unmapped access not refused");
  // Relay 3 mirrors the not-ready indication
  a_nrdy_relay: assert property ($past(rstn) |-> relayOut[2] == notReady)
    else $error("relay 3 and not-ready differ");
  // A shorted close and trip pair would fight the breaker coils
  a_close_trip_excl: assert property (!(relayOut[0] && relayOut[1]))
    else $error("close and trip together");
  a_ready_pair: assert property (relayOut[4] == relayOut[6])
    else $error("ready relays differ");
  a_close_end: assert property (brkClosedIn [*5] |-> !relayOut[1])
    else $error("close held on closed breaker");
  a_peer_uv: assert property ($rose(peerUvIn) && relayOut[4] &&
    !relayOut[3] |-> ##[1:5] notReady) else $error("peer sag not shown");
  a_lock_trip: assert property ($rose(lockoutIn) && brkClosedIn &&
    relayOut[4] |-> ##[1:5] relayOut[0]) else $error("lockout no trip");
  c_unmapped: cover property (pready && pslverr);
  c_req_sent: cover property ($rose(relayOut[5]));
  c_ready: cover property ($fell(notReady));
endmodule : bts_scheme_asserts
bind bts_scheme_top bts_scheme_asserts bts_scheme_asserts_inst (
  .clk, .rstn, .psel, .penable, .paddr, .pready, .pslverr, .brkClosedIn,
  .lockoutIn, .peerUvIn, .relayOut, .notReady);
`default_nettype wire

// ===== sim/bus_transfer_scheme_logic_tb.sv
// Self-checking bench for the scheme top in incomer and bus tie roles.
// Assumes the breaker model closes the loop from relays to aux contact.
`timescale 1ns/1ns
`default_nettype none
module bus_transfer_scheme_logic_tb;
  import bts_pkg::*;
  localparam logic [7:0] ALL = 8'hFF;
  localparam logic [7:0] TIE = 8'h78;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, seed = 32'h0000_3606;
  logic [16:0] pin = 17'h0;
  logic [31:0] prdata;
  logic pready, pslverr, brkClosedIn, notReady;
  logic [6:0] relayOut;
  logic [7:0] rqv[$], rqm[$];
  logic [32:0] aq[$];
  int miscompares = 0, check_count = 0, cyc = 0;

  bts_scheme_top #(.MS_CYCLES(10)) bts_scheme_top_inst (
    .clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .brkConnIn(pin[0]), .remCloseIn(pin[1]),
    .remOpenIn(pin[2]), .blockXferIn(pin[3]), .lockoutIn(pin[4]),
    .brkClosedIn, .uvFastIn(pin[6]), .uvTimedIn(pin[7]),
    .lineLiveIn(pin[8]), .busDeadIn(pin[9]), .lineDeadIn(pin[10]),
    .reqInc1In(pin[11]), .reqInc2In(pin[12]), .peerReadyIn(pin[13]),
    .peerUvIn(pin[14]), .tieConnIn(pin[15]), .tieClosedIn(pin[16]),
    .relayOut, .notReady);
  bts_breaker_model bts_breaker_model_inst (.clk, .rstn,
    .closeCmd(relayOut[1]), .tripCmd(relayOut[0]), .closed(brkClosedIn));

  always #10 clk = ~clk;

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Let relays settle, then note the expected {notReady, relays}
  task automatic st(input int n, input logic [7:0] m, input logic [7:0] v);
    repeat (n) @(posedge clk);
    rqm.push_back(m);
    rqv.push_back(v);
  endtask

  // Random pulse length: any width must give one command only
  task automatic pulse(input int i);
    pin[i] <= 1'b1;
    repeat (2 + rnd() % 24) @(posedge clk);
    pin[i] <= 1'b0;
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d, input logic [32:0] e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    if (!w) aq.push_back(e);
    // Only the bench timeout ends a wait for the answer
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic waitrly(input int b, input logic v);
    int t = 0;
    while (relayOut[b] !== v && t < 40) begin
      @(posedge clk);
      t++;
    end
    check({32'h0, relayOut[b]}, {32'h0, v});
  endtask

  // Relay notes are compared half a cycle after they are made
  always @(negedge clk) begin
    if (rqv.size() > 0) begin
      check({25'h0, {notReady, relayOut} & rqm[0]}, {25'h0, rqv[0]});
      rqm.delete(0);
      rqv.delete(0);
    end
  end

  // Read data is taken at the edge where the answer is sampled
  always @(posedge clk) begin
    cyc++;
    if (psel & penable & !pwrite & (pready === 1'b1) & aq.size() > 0) begin
      check({pslverr, prdata}, aq[0]);
      aq.delete(0);
    end
    if (cyc == 6000) begin
      miscompares++;
      give_verdict();
    end
  end

  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    st(6, ALL, 8'h8D);
    apb(1'b0, OFS_CTRL, 32'h0, {1'b0, CTRL_RST});
    apb(1'b0, OFS_DELAY, 32'h0, {17'h0, DELAY_RST});
    apb(1'b0, 12'h010, 32'h0, {1'b1, 32'h0});
    apb(1'b1, OFS_DELAY, 32'h2, 33'h0);
    apb(1'b1, OFS_INPUTS, 32'hFFFF, 33'h0);
    apb(1'b0, OFS_INPUTS, 32'h0, 33'h0);
    apb(1'b0, OFS_DELAY, 32'h0, 33'h2);
    pin[IN_PEERRDY] <= 1'b1;
    pin[IN_TIECONN] <= 1'b1;
    pin[IN_CONN] <= 1'b1;
    pulse(IN_RCLOSE);
    st(24, ALL, 8'h8D);
    pin[IN_LINELIVE] <= 1'b1;
    st(24, ALL, 8'h50);
    pin[IN_TIECONN] <= 1'b0;
    st(24, ALL, 8'hD4);
    pin[IN_TIECONN] <= 1'b1;
    st(24, ALL, 8'h50);
    pin[IN_CONN] <= 1'b0;
    st(24, ALL, 8'h84);
    pin[IN_CONN] <= 1'b1;
    st(24, ALL, 8'h50);
    pin[IN_BLOCK] <= 1'b1;
    st(24, ALL, 8'h84);
    pin[IN_BLOCK] <= 1'b0;
    st(24, ALL, 8'h50);
    pin[IN_TIECLOSED] <= 1'b1;
    st(24, ALL, 8'hD4);
    pin[IN_TIECLOSED] <= 1'b0;
    pin[IN_PEERRDY] <= 1'b0;
    st(24, ALL, 8'hD4);
    pin[IN_PEERRDY] <= 1'b1;
    pulse(IN_ROPEN);
    st(24, ALL, 8'h85);
    pulse(IN_RCLOSE);
    st(24, ALL, 8'h50);
    pin[IN_UVFAST] <= 1'b1;
    st(24, ALL, 8'h58);
    pin[IN_UVFAST] <= 1'b0;
    pin[IN_PEERUV] <= 1'b1;
    st(8, ALL, 8'hD4);
    pin[IN_PEERUV] <= 1'b0;
    st(8, ALL, 8'hD4);
    st(24, ALL, 8'h50);
    pin[IN_UVTIMED] <= 1'b1;
    st(24, ALL, 8'h85);
    pin[IN_UVTIMED] <= 1'b0;
    pulse(IN_RCLOSE);
    st(24, ALL, 8'h50);
    pin[IN_LOCKOUT] <= 1'b1;
    waitrly(5, 1'b1);
    waitrly(5, 1'b0);
    check({32'h0, brkClosedIn}, 33'h0);
    st(8, ALL, 8'h85);
    pin[IN_LOCKOUT] <= 1'b0;
    pin[IN_CONN] <= 1'b0;
    apb(1'b1, OFS_CTRL, 32'h0000_0006, 33'h0);
    st(24, TIE, 8'h00);
    pin[IN_CONN] <= 1'b1;
    st(24, TIE, 8'h28);
    pulse(IN_RCLOSE);
    st(24, TIE, 8'h78);
    pulse(IN_ROPEN);
    st(24, TIE, 8'h28);
    pin[IN_REQ1] <= 1'b1;
    st(24, TIE, 8'h28);
    pin[IN_BUSDEAD] <= 1'b1;
    st(24, TIE, 8'h78);
    pin[IN_REQ1] <= 1'b0;
    pulse(IN_ROPEN);
    st(24, TIE, 8'h28);
    pin[IN_REQ2] <= 1'b1;
    st(24, TIE, 8'h28);
    pin[IN_LINEDEAD] <= 1'b1;
    st(24, TIE, 8'h78);
    pin[IN_CONN] <= 1'b0;
    st(24, TIE, 8'h00);
    // Reset in mid-run: settings return to their reset values
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    apb(1'b0, OFS_CTRL, 32'h0, {1'b0, CTRL_RST});
    apb(1'b0, OFS_DELAY, 32'h0, {17'h0, DELAY_RST});
    st(6, ALL, 8'h85);
    st(2, 8'h00, 8'h00);
    give_verdict();
  end
endmodule : bus_transfer_scheme_logic_tb
`default_nettype wire
